// *** design/csrb_bank.sv ***
// Purpose: core special register bank, addresses 0x0 to 0x9 in every bank
// Assumes: core issues one access and one pc operation per instruction cycle
// Notes: indirect access above 0x1f goes out on the gpr port; read data is registered
// Functional notes
// - indirect port has no storage; accesses go to pointer-addressed register
// - timer0 reads return the live count; writes replace the count
// - timer0 ticks from instruction clock, external pin or low oscillator
// - pc low byte is bits 7:0 of pc; pc steps one per instruction
// - pc bits 10:8 change through the high buffer, a jump, a call or a step carry
// - long jump loads all eleven pc bits from the instruction
// - long call loads pc from instruction and pushes pc plus one
// - carry set on add carry or subtract no-borrow, else cleared
// - half carry set on nibble carry or nibble no-borrow, else cleared
// - zero flag follows whether the result is zero
// - power-down flag is one after reset or clear-watchdog, zero after sleep
// - time-out flag one after reset, clear-watchdog, sleep; zero on timeout
// - two status bank bits choose one of four banks
// - pointer low seven bits pick a register; top bit is spare storage
// - port read gives pin for inputs, pin or latch for outputs by option
// - port write stores into the output latch whatever the direction
// - watchdog enable bit resets to one
// - low-voltage reset enable bit resets to one
// - low-voltage detector enable bit resets to zero
// - pa5 pull-up disable bit, active low enable, resets to one
// - spare power-control bits are plain storage resetting to zero
// - each port-b wake enable bit resets to one
// - addresses 0x0 to 0x1f in every bank reach the bank-0 registers
// - indirect address is bank bits joined with pointer low seven bits
`timescale 1ns/1ps
module csrb_bank (
  input wire logic core_clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire csrb_pkg::csrb_acc_s acc, // direct access, address op[6:0]
  output logic [7:0] rdata, // read data, one cycle after rd
  output logic [8:0] gpr_addr, // bank and location to data memory
  output logic gpr_rd, // data memory read strobe
  output logic gpr_wr, // data memory write strobe
  output logic [7:0] gpr_wdata, // data memory write data
  input wire logic [7:0] gpr_rdata, // data memory read data
  input wire csrb_pkg::csrb_pcop_e pc_op, // program counter operation
  input wire logic [10:0] pc_target, // address field of long jump or call
  input wire logic [2:0] pc_high_buffer, // high pc buffer contents
  output logic [10:0] pc, // program counter
  output logic stack_push, // push return address
  output logic [10:0] stack_data, // return address
  input wire csrb_pkg::csrb_alu_s alu, // flag results
  input wire logic sleep_exec, // sleep instruction executed
  input wire logic clrwdt_exec, // clear-watchdog instruction executed
  input wire logic wdt_timeout, // watchdog timeout event
  input wire csrb_pkg::csrb_t0src_e timer0_mode_setting, // timer0 source
  input wire logic timer0_run, // timer0 counting allowed
  input wire logic timer0_external_clock_pin, // external timer0 clock pin
  input wire logic low_osc_clk, // low oscillator, sampled as a pin
  input wire logic instruction_clock, // one-cycle instruction tick
  input wire logic port_read_option, // 1: output pins read latch
  input wire logic [7:0] pa_pin, // port a pin levels
  input wire logic [7:0] pb_pin, // port b pin levels
  input wire logic [1:0] pc_pin, // port c pin levels
  input wire logic [7:0] pa_dir_in, // 1 marks an input pin
  input wire logic [7:0] pb_dir_in, // 1 marks an input pin
  input wire logic [1:0] pc_dir_in, // 1 marks an input pin
  output logic [7:0] port_a_data, // port a output latch
  output logic [7:0] port_b_data, // port b output latch
  output logic [1:0] port_c_data, // port c output latch
  output logic [1:0] bank_select, // current bank
  output logic watchdog_enable, // watchdog on
  output logic low_voltage_detect_enable, // detector on
  output logic low_voltage_reset_enable, // low-voltage reset on
  output logic pa5_pullup_disable, // 0 enables pa5 pull-up
  output logic [7:0] pin_wake_enable // port b wake enables
);
  import csrb_pkg::*;

  csrb_state_s s_reg;
  csrb_state_s s_next;
  logic [6:0] eff_addr;
  logic ind;
  logic sfr_hit;
  logic t0_tick;
  logic st_wr;

  function automatic logic [7:0] port_view(input logic [7:0] pin,
      input logic [7:0] lat, input logic [7:0] dir_in);
    port_view = (pin & dir_in) |
        ((port_read_option ? lat : pin) & ~dir_in);
  endfunction : port_view

  // indirect accesses redirect through the pointer
  assign ind = (acc.addr == CSRB_OFF_INDIRECT);
  assign eff_addr = ind ? s_reg.fsp[6:0] : acc.addr;
  // low addresses land in bank 0 whatever the bank bits; an indirect
  // access through a zero pointer lands here too and does nothing
  assign sfr_hit = (eff_addr <= CSRB_SFR_LAST);
  assign gpr_addr = {s_reg.status[CSRB_ST_BK0+1:CSRB_ST_BK0],
      eff_addr};
  assign gpr_rd = acc.rd && !sfr_hit;
  assign gpr_wr = acc.wr && !sfr_hit;
  assign gpr_wdata = acc.wdata;
  assign st_wr = acc.wr && sfr_hit && (eff_addr == CSRB_OFF_STATUS);

  // edge detect after the two-stage synchronisers
  always_comb begin
    unique case (timer0_mode_setting)
      CSRB_T0_INST: t0_tick = instruction_clock;
      CSRB_T0_EXT: t0_tick = s_reg.ext_s[1] & ~s_reg.ext_s[2];
      CSRB_T0_LOSC: t0_tick = s_reg.losc_s[1] & ~s_reg.losc_s[2];
      default: t0_tick = 1'b0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.ext_s = {s_reg.ext_s[1:0], timer0_external_clock_pin};
    s_next.losc_s = {s_reg.losc_s[1:0], low_osc_clk};
    s_next.pa_s1 = pa_pin;
    s_next.pa_s2 = s_reg.pa_s1;
    s_next.pb_s1 = pb_pin;
    s_next.pb_s2 = s_reg.pb_s1;
    s_next.pc_s1 = pc_pin;
    s_next.pc_s2 = s_reg.pc_s1;
    if (timer0_run && t0_tick) begin
      s_next.timer0 = s_reg.timer0 + 8'h01;
    end
    unique case (pc_op)
      CSRB_PC_STEP: s_next.pc = s_reg.pc + 11'h001;
      CSRB_PC_HOLD: s_next.pc = s_reg.pc;
      CSRB_PC_JUMP: s_next.pc = pc_target;
      CSRB_PC_CALL: s_next.pc = pc_target;
      default: s_next.pc = s_reg.pc;
    endcase
    if (alu.upd_c) begin
      s_next.status[CSRB_ST_C] = alu.c;
    end
    if (alu.upd_dc) begin
      s_next.status[CSRB_ST_DC] = alu.dc;
    end
    if (alu.upd_z) begin
      s_next.status[CSRB_ST_Z] = alu.z;
    end
    if (acc.wr && sfr_hit) begin
      unique case (eff_addr)
        CSRB_OFF_TIMER0: s_next.timer0 = acc.wdata;
        CSRB_OFF_PCL: s_next.pc = {pc_high_buffer, acc.wdata};
        CSRB_OFF_STATUS: s_next.status = acc.wdata;
        CSRB_OFF_FSP: s_next.fsp = acc.wdata;
        CSRB_OFF_PORT_A_DATA: s_next.lat_a = acc.wdata;
        CSRB_OFF_PORT_B_DATA: s_next.lat_b = acc.wdata;
        CSRB_OFF_PORT_C_DATA: s_next.lat_c = acc.wdata & CSRB_PORT_C_DATA_MASK;
        CSRB_OFF_PWR: s_next.pwr = acc.wdata;
        CSRB_OFF_WAKE: s_next.wake = acc.wdata;
        default: s_next.rdata = s_reg.rdata;
      endcase
    end
    // instruction events win over a software write to the same bits
    if (sleep_exec) begin
      s_next.status[CSRB_ST_PD] = 1'b0;
      s_next.status[CSRB_ST_TO] = 1'b1;
    end
    if (clrwdt_exec) begin
      s_next.status[CSRB_ST_PD] = 1'b1;
      s_next.status[CSRB_ST_TO] = 1'b1;
    end
    if (wdt_timeout) begin
      s_next.status[CSRB_ST_TO] = 1'b0;
    end
    if (acc.rd) begin
      if (!sfr_hit) begin
        s_next.rdata = gpr_rdata;
      end else begin
        unique case (eff_addr)
          CSRB_OFF_TIMER0: s_next.rdata = s_reg.timer0;
          CSRB_OFF_PCL: s_next.rdata = s_reg.pc[7:0];
          CSRB_OFF_STATUS: s_next.rdata = s_reg.status;
          CSRB_OFF_FSP: s_next.rdata = s_reg.fsp;
          CSRB_OFF_PORT_A_DATA: s_next.rdata =
              port_view(s_reg.pa_s2, s_reg.lat_a, pa_dir_in);
          CSRB_OFF_PORT_B_DATA: s_next.rdata =
              port_view(s_reg.pb_s2, s_reg.lat_b, pb_dir_in);
          CSRB_OFF_PORT_C_DATA: s_next.rdata = port_view({6'h00, s_reg.pc_s2},
              s_reg.lat_c, {6'h00, pc_dir_in}) & CSRB_PORT_C_DATA_MASK;
          CSRB_OFF_PWR: s_next.rdata = s_reg.pwr;
          CSRB_OFF_WAKE: s_next.rdata = s_reg.wake;
          default: s_next.rdata = CSRB_RST_BYTE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.pc <= CSRB_RST_PC;
      s_reg.status <= CSRB_RST_STATUS;
      s_reg.fsp <= CSRB_RST_FSP;
      s_reg.pwr <= CSRB_RST_PWR;
      s_reg.wake <= CSRB_RST_WAKE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign pc = s_reg.pc;
  assign stack_push = (pc_op == CSRB_PC_CALL);
  assign stack_data = s_reg.pc + 11'h001;
  assign port_a_data = s_reg.lat_a;
  assign port_b_data = s_reg.lat_b;
  assign port_c_data = s_reg.lat_c[1:0];
  assign bank_select = s_reg.status[CSRB_ST_BK0+1:CSRB_ST_BK0];
  assign watchdog_enable = s_reg.pwr[CSRB_PW_WDT];
  assign low_voltage_detect_enable = s_reg.pwr[CSRB_PW_LVD];
  assign low_voltage_reset_enable = s_reg.pwr[CSRB_PW_LVR];
  assign pa5_pullup_disable = s_reg.pwr[CSRB_PW_PA5];
  assign pin_wake_enable = s_reg.wake;

  // address decode and data-memory redirection
  a_sfr_alias: assert property (@(posedge core_clk)
      disable iff (!nrst)
      acc.wr && !ind && acc.addr <= CSRB_SFR_LAST |-> !gpr_wr)
    else $error("sfr write leaked to memory");
  a_gpr_range: assert property (@(posedge core_clk)
      disable iff (!nrst)
      gpr_rd || gpr_wr |-> gpr_addr[6:0] > CSRB_SFR_LAST)
    else $error("memory strobe for a special address");
  a_refused_write: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr > CSRB_OFF_WAKE &&
      acc.addr <= CSRB_SFR_LAST |=> $stable(s_reg.pwr) && $stable(s_reg.wake))
    else $error("unused address changed a register");
  a_refused_read: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.rd && !ind && acc.addr > CSRB_OFF_WAKE &&
      acc.addr <= CSRB_SFR_LAST |=> rdata == CSRB_RST_BYTE)
    else $error("unused address read not zero");
  a_indirect_addr: assert property (@(posedge core_clk)
      disable iff (!nrst)
      ind && gpr_rd |-> gpr_addr == {bank_select, s_reg.fsp[6:0]})
    else $error("indirect address wrong");
  a_ind_wr_addr: assert property (@(posedge core_clk)
      disable iff (!nrst)
      ind && gpr_wr |-> gpr_addr == {bank_select, s_reg.fsp[6:0]})
    else $error("indirect write address wrong");
  a_direct_addr: assert property (@(posedge core_clk)
      disable iff (!nrst)
      !ind && (gpr_rd || gpr_wr) |-> gpr_addr == {bank_select, acc.addr})
    else $error("direct address wrong");
  a_ind_write: assert property (@(posedge core_clk)
      disable iff (!nrst) ind && acc.wr && s_reg.fsp[6:0] > CSRB_SFR_LAST
      |-> gpr_wr && gpr_wdata == acc.wdata)
    else $error("indirect write not redirected");
  a_ind_read: assert property (@(posedge core_clk)
      disable iff (!nrst) ind && acc.rd && s_reg.fsp[6:0] > CSRB_SFR_LAST
      |=> rdata == $past(gpr_rdata))
    else $error("indirect read not redirected");
  a_ind_null: assert property (@(posedge core_clk)
      disable iff (!nrst) ind && acc.rd &&
      s_reg.fsp[6:0] == CSRB_OFF_INDIRECT |=> rdata == CSRB_RST_BYTE)
    else $error("indirect self read not zero");

  // timer0 count
  a_timer_write: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr == CSRB_OFF_TIMER0
      |=> s_reg.timer0 == $past(acc.wdata))
    else $error("timer0 write lost");
  a_timer_read: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.rd && !ind && acc.addr == CSRB_OFF_TIMER0
      |=> rdata == $past(s_reg.timer0))
    else $error("timer0 read not live");
  a_timer_tick: assert property (@(posedge core_clk)
      disable iff (!nrst) timer0_run && t0_tick && !(acc.wr && sfr_hit &&
      eff_addr == CSRB_OFF_TIMER0) |=> s_reg.timer0 == $past(s_reg.timer0) +
      8'h01)
    else $error("timer0 missed a tick");
  a_timer_idle: assert property (@(posedge core_clk)
      disable iff (!nrst)
      !timer0_run && !acc.wr |=> $stable(s_reg.timer0))
    else $error("timer0 moved while stopped");

  // program counter
  a_pc_step: assert property (@(posedge core_clk)
      disable iff (!nrst)
      pc_op == CSRB_PC_STEP && !acc.wr |=> pc == $past(pc) + 11'h001)
    else $error("pc did not step");
  a_pc_hold: assert property (@(posedge core_clk)
      disable iff (!nrst)
      pc_op == CSRB_PC_HOLD && !acc.wr |=> $stable(pc))
    else $error("pc moved on hold");
  a_pcl_read: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.rd && !ind && acc.addr == CSRB_OFF_PCL
      |=> rdata == $past(pc[7:0]))
    else $error("pc low byte read wrong");
  a_pcl_write: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr == CSRB_OFF_PCL
      |=> pc == {$past(pc_high_buffer), $past(acc.wdata)})
    else $error("pc low byte write wrong");
  a_pc_high_hold: assert property (@(posedge core_clk)
      disable iff (!nrst) pc_op == CSRB_PC_STEP && !acc.wr &&
      pc[7:0] != 8'hff |=> pc[10:8] == $past(pc[10:8]))
    else $error("pc high bits changed");
  a_jump_load: assert property (@(posedge core_clk)
      disable iff (!nrst)
      pc_op == CSRB_PC_JUMP && !acc.wr |=> pc == $past(pc_target))
    else $error("jump target not loaded");
  a_call_load: assert property (@(posedge core_clk)
      disable iff (!nrst)
      pc_op == CSRB_PC_CALL && !acc.wr |=> pc == $past(pc_target))
    else $error("call target not loaded");
  a_call_push: assert property (@(posedge core_clk)
      disable iff (!nrst) stack_push && !acc.wr
      |=> $past(stack_data) == $past(pc) + 11'h001)
    else $error("bad return address");

  // status and pointer
  a_carry_flag: assert property (@(posedge core_clk)
      disable iff (!nrst) alu.upd_c && !st_wr
      |=> s_reg.status[CSRB_ST_C] == $past(alu.c))
    else $error("carry flag wrong");
  a_half_carry: assert property (@(posedge core_clk)
      disable iff (!nrst) alu.upd_dc && !st_wr
      |=> s_reg.status[CSRB_ST_DC] == $past(alu.dc))
    else $error("half carry flag wrong");
  a_zero_flag: assert property (@(posedge core_clk)
      disable iff (!nrst) alu.upd_z && !st_wr
      |=> s_reg.status[CSRB_ST_Z] == $past(alu.z))
    else $error("zero flag wrong");
  a_sleep_flags: assert property (@(posedge core_clk)
      disable iff (!nrst) sleep_exec && !clrwdt_exec && !wdt_timeout
      |=> !s_reg.status[CSRB_ST_PD] && s_reg.status[CSRB_ST_TO])
    else $error("sleep flags wrong");
  a_clrwdt_flags: assert property (@(posedge core_clk)
      disable iff (!nrst) clrwdt_exec && !wdt_timeout
      |=> s_reg.status[CSRB_ST_PD] && s_reg.status[CSRB_ST_TO])
    else $error("clear-watchdog flags wrong");
  a_timeout_flag: assert property (@(posedge core_clk)
      disable iff (!nrst)
      wdt_timeout |=> !s_reg.status[CSRB_ST_TO])
    else $error("timeout flag not cleared");
  a_sleep_to: assert property (@(posedge core_clk)
      disable iff (!nrst)
      sleep_exec && !wdt_timeout |=> s_reg.status[CSRB_ST_TO])
    else $error("time-out flag not set by sleep");
  a_status_write: assert property (@(posedge core_clk)
      disable iff (!nrst) st_wr && !sleep_exec && !clrwdt_exec &&
      !wdt_timeout |=> s_reg.status == $past(acc.wdata))
    else $error("status write lost");
  a_fsp_write: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr == CSRB_OFF_FSP
      |=> s_reg.fsp == $past(acc.wdata))
    else $error("pointer write lost");

  // port data
  a_port_a_data_latch: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr == CSRB_OFF_PORT_A_DATA
      |=> port_a_data == $past(acc.wdata))
    else $error("port a latch wrong");
  a_port_b_data_latch: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr == CSRB_OFF_PORT_B_DATA
      |=> port_b_data == $past(acc.wdata))
    else $error("port b latch wrong");
  a_port_c_data_latch: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr == CSRB_OFF_PORT_C_DATA
      |=> port_c_data == $past(acc.wdata[1:0]))
    else $error("port c latch wrong");
  a_port_c_data_zero: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.rd && !ind && acc.addr == CSRB_OFF_PORT_C_DATA
      |=> rdata[7:2] == 6'h00)
    else $error("port c upper bits not zero");
  a_port_a_data_pin: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.rd && !ind && acc.addr == CSRB_OFF_PORT_A_DATA &&
      !port_read_option |=> rdata == $past(s_reg.pa_s2))
    else $error("port a pin read wrong");
  a_port_b_data_pin: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.rd && !ind && acc.addr == CSRB_OFF_PORT_B_DATA &&
      !port_read_option |=> rdata == $past(s_reg.pb_s2))
    else $error("port b pin read wrong");

  // power control and wake enables
  a_pwr_write: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr == CSRB_OFF_PWR
      |=> s_reg.pwr == $past(acc.wdata))
    else $error("power control write lost");
  a_wake_write: assert property (@(posedge core_clk)
      disable iff (!nrst) acc.wr && !ind && acc.addr == CSRB_OFF_WAKE
      |=> pin_wake_enable == $past(acc.wdata))
    else $error("wake enable write lost");

  c_call: cover property (@(posedge core_clk) stack_push);
  c_ind_read: cover property (@(posedge core_clk) ind && gpr_rd);
  c_sleep: cover property (@(posedge core_clk) sleep_exec);
  c_ext_tick: cover property (@(posedge core_clk)
      timer0_mode_setting == CSRB_T0_EXT && t0_tick);
  c_refused: cover property (@(posedge core_clk)
      acc.rd && acc.addr > CSRB_OFF_WAKE && acc.addr <= CSRB_SFR_LAST);
endmodule : csrb_bank

// *** design/csrb_pkg.sv ***
// Purpose: shared constants and carriers for the core special register bank
// Assumes: 8-bit data path, 11-bit program counter
// Notes: offsets are word addresses on the core data-memory bus
package csrb_pkg;
  localparam logic [6:0] CSRB_OFF_INDIRECT = 7'h00;
  localparam logic [6:0] CSRB_OFF_TIMER0 = 7'h01;
  localparam logic [6:0] CSRB_OFF_PCL = 7'h02;
  localparam logic [6:0] CSRB_OFF_STATUS = 7'h03;
  localparam logic [6:0] CSRB_OFF_FSP = 7'h04;
  localparam logic [6:0] CSRB_OFF_PORT_A_DATA = 7'h05;
  localparam logic [6:0] CSRB_OFF_PORT_B_DATA = 7'h06;
  localparam logic [6:0] CSRB_OFF_PORT_C_DATA = 7'h07;
  localparam logic [6:0] CSRB_OFF_PWR = 7'h08;
  localparam logic [6:0] CSRB_OFF_WAKE = 7'h09;
  localparam logic [6:0] CSRB_SFR_LAST = 7'h1f;
  localparam int CSRB_ST_C = 0;
  localparam int CSRB_ST_DC = 1;
  localparam int CSRB_ST_Z = 2;
  localparam int CSRB_ST_PD = 3;
  localparam int CSRB_ST_TO = 4;
  localparam int CSRB_ST_BK0 = 6;
  localparam int CSRB_PW_LVR = 3;
  localparam int CSRB_PW_PA5 = 4;
  localparam int CSRB_PW_LVD = 5;
  localparam int CSRB_PW_WDT = 7;
  localparam logic [7:0] CSRB_RST_STATUS = 8'h18;
  localparam logic [7:0] CSRB_RST_FSP = 8'h00;
  localparam logic [7:0] CSRB_RST_PWR = 8'h98;
  localparam logic [7:0] CSRB_RST_WAKE = 8'hff;
  localparam logic [7:0] CSRB_RST_BYTE = 8'h00;
  localparam logic [10:0] CSRB_RST_PC = 11'h000;
  localparam logic [7:0] CSRB_PORT_C_DATA_MASK = 8'h03;

  typedef enum logic [1:0] {
    CSRB_T0_INST = 2'b00,
    CSRB_T0_EXT = 2'b01,
    CSRB_T0_LOSC = 2'b10
  } csrb_t0src_e;

  typedef enum logic [2:0] {
    CSRB_PC_STEP = 3'b000,
    CSRB_PC_HOLD = 3'b001,
    CSRB_PC_JUMP = 3'b010,
    CSRB_PC_CALL = 3'b011
  } csrb_pcop_e;

  // data-memory access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } csrb_acc_s;

  // flag results of an executed ALU instruction
  typedef struct packed {
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic c;
    logic dc;
    logic z;
  } csrb_alu_s;

  typedef struct packed {
    logic [7:0] timer0;
    logic [10:0] pc;
    logic [7:0] status;
    logic [7:0] fsp;
    logic [7:0] lat_a;
    logic [7:0] lat_b;
    logic [7:0] lat_c;
    logic [7:0] pwr;
    logic [7:0] wake;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pb_s1;
    logic [7:0] pb_s2;
    logic [1:0] pc_s1;
    logic [1:0] pc_s2;
    logic [2:0] ext_s;
    logic [2:0] losc_s;
    logic [7:0] rdata;
  } csrb_state_s;
endpackage : csrb_pkg

// *** tb/csrb_gpr_model.sv ***
// Purpose: data memory behind the bank for addresses above 0x1f
// Assumes: same-cycle read data, write taken on the rising edge
// Notes: an idle read bus shows the inverse of the last value
`timescale 1ns/1ps
module csrb_gpr_model (
  input wire logic core_clk, // core clock
  input wire logic [8:0] gpr_addr, // bank and location
  input wire logic gpr_rd, // read strobe
  input wire logic gpr_wr, // write strobe
  input wire logic [7:0] gpr_wdata, // write data
  output logic [7:0] gpr_rdata // read data, same cycle
);
  logic [7:0] mem [0:511];
  logic [7:0] last_reg = 8'h00;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'h00;
  end
  assign gpr_rdata = gpr_rd ? mem[gpr_addr] : ~last_reg;
  always @(posedge core_clk) begin
    if (gpr_wr) mem[gpr_addr] <= gpr_wdata;
    if (gpr_rd) last_reg <= mem[gpr_addr];
  end
endmodule : csrb_gpr_model

// *** tb/test_core_special_register_bank.sv ***
// Purpose: register-level tests of the core special register bank
// Assumes: inputs change on the falling edge
// Notes: port reads wait out the two-flop pin sync
`timescale 1ns/1ps
module test_core_special_register_bank;
  import csrb_pkg::*;
  logic core_clk = 0, nrst = 0;
  csrb_acc_s acc = '0;
  csrb_pcop_e pc_op = CSRB_PC_HOLD;
  csrb_alu_s alu = '0;
  csrb_t0src_e t0m = CSRB_T0_INST;
  logic [10:0] tgt = 11'h000, pc, sdat;
  logic [2:0] pch = 3'h5;
  logic slp = 0, clr = 0, wto = 0, run = 0, ext = 0, losc = 0, itk = 0;
  logic opt = 0, push, grd, gwr, wdt, low_voltage_detector, low_voltage_reset, pa5;
  logic [7:0] pap = 0, pbp = 0, pad = 0, pbd = 0, rdata, grdat, gwdat;
  logic [7:0] pao, pbo, wake;
  logic [1:0] pcp = 0, pcd = 0, pco, bank;
  logic [8:0] gaddr;
  int err_count = 0, check_count = 0;
  csrb_bank dut (.core_clk(core_clk), .nrst(nrst), .acc(acc), .rdata(rdata),
    .gpr_addr(gaddr), .gpr_rd(grd), .gpr_wr(gwr), .gpr_wdata(gwdat),
    .gpr_rdata(grdat), .pc_op(pc_op), .pc_target(tgt), .pc_high_buffer(pch),
    .pc(pc), .stack_push(push), .stack_data(sdat), .alu(alu),
    .sleep_exec(slp), .clrwdt_exec(clr), .wdt_timeout(wto),
    .timer0_mode_setting(t0m), .timer0_run(run),
    .timer0_external_clock_pin(ext), .low_osc_clk(losc),
    .instruction_clock(itk), .port_read_option(opt), .pa_pin(pap),
    .pb_pin(pbp), .pc_pin(pcp), .pa_dir_in(pad), .pb_dir_in(pbd),
    .pc_dir_in(pcd), .port_a_data(pao), .port_b_data(pbo), .port_c_data(pco),
    .bank_select(bank), .watchdog_enable(wdt), .low_voltage_detect_enable(low_voltage_detector),
    .low_voltage_reset_enable(low_voltage_reset), .pa5_pullup_disable(pa5),
    .pin_wake_enable(wake));
  csrb_gpr_model gpr (.core_clk(core_clk), .gpr_addr(gaddr), .gpr_rd(grd),
    .gpr_wr(gwr), .gpr_wdata(gwdat), .gpr_rdata(grdat));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task chk(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    acc = '{1'b0, 1'b1, a, d};
    @(negedge core_clk);
    acc = '0;
  endtask : wr
  task rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    acc = '{1'b1, 1'b0, a, 8'h00};
    @(negedge core_clk);
    acc = '0;
    chk({3'h0, rdata}, {3'h0, exp});
  endtask : rd
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #20000;
    err_count++;
    print_verdict;
  end
  initial begin
    cyc(8);
    nrst = 1;
    rd(7'h08, 8'h98);
    rd(7'h09, 8'hff);
    rd(7'h03, 8'h18);
    rd(7'h02, 8'h00);
    $display("reset values done");
    wr(7'h08, 8'h47);
    chk({7'h0, wdt, low_voltage_detector, pa5, low_voltage_reset}, 11'h000);
    wr(7'h08, 8'ha8);
    chk({7'h0, wdt, low_voltage_detector, pa5, low_voltage_reset}, 11'h00d);
    rd(7'h08, 8'ha8);
    wr(7'h09, 8'h3c);
    chk({3'h0, wake}, 11'h03c);
    wr(7'h0a, 8'h55);
    rd(7'h0a, 8'h00);
    $display("power and wake done");
    @(negedge core_clk) alu = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    @(negedge core_clk) alu = '0;
    rd(7'h03, 8'h1d);
    @(negedge core_clk) alu = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    @(negedge core_clk) alu = '0;
    rd(7'h03, 8'h1a);
    @(negedge core_clk) slp = 1;
    @(negedge core_clk) slp = 0;
    rd(7'h03, 8'h12);
    @(negedge core_clk) wto = 1;
    @(negedge core_clk) wto = 0;
    rd(7'h03, 8'h02);
    @(negedge core_clk) clr = 1;
    @(negedge core_clk) clr = 0;
    rd(7'h03, 8'h1a);
    $display("status flags done");
    wr(7'h04, 8'ha5);
    wr(7'h03, 8'h98);
    chk({9'h0, bank}, 11'h002);
    wr(7'h00, 8'h6e);
    chk({3'h0, gpr.mem[9'h125]}, 11'h06e);
    rd(7'h00, 8'h6e);
    rd(7'h04, 8'ha5);
    rd(7'h09, 8'h3c);
    wr(7'h04, 8'h00);
    wr(7'h00, 8'h77);
    chk({3'h0, gpr.mem[9'h100]}, 11'h000);
    rd(7'h00, 8'h00);
    $display("indirect done");
    pad = 8'hf0;
    pap = 8'h5a;
    opt = 1;
    wr(7'h05, 8'h3c);
    chk({3'h0, pao}, 11'h03c);
    cyc(3);
    rd(7'h05, 8'h5c);
    opt = 0;
    rd(7'h05, 8'h5a);
    pbd = 8'hff;
    pbp = 8'h81;
    wr(7'h06, 8'hc3);
    chk({3'h0, pbo}, 11'h0c3);
    cyc(3);
    rd(7'h06, 8'h81);
    pcp = 2'b10;
    opt = 1;
    wr(7'h07, 8'hff);
    chk({9'h0, pco}, 11'h003);
    cyc(3);
    rd(7'h07, 8'h03);
    $display("ports done");
    wr(7'h01, 8'h10);
    rd(7'h01, 8'h10);
    @(negedge core_clk) {run, itk} = 2'b11;
    @(negedge core_clk) {run, itk} = 2'b00;
    rd(7'h01, 8'h11);
    t0m = CSRB_T0_EXT;
    run = 1;
    ext = 1;
    cyc(4);
    rd(7'h01, 8'h12);
    t0m = CSRB_T0_LOSC;
    losc = 1;
    cyc(4);
    rd(7'h01, 8'h13);
    run = 0;
    $display("timer done");
    @(negedge core_clk);
    pc_op = CSRB_PC_JUMP;
    tgt = 11'h2f0;
    @(negedge core_clk) pc_op = CSRB_PC_STEP;
    chk(pc, 11'h2f0);
    @(negedge core_clk);
    pc_op = CSRB_PC_CALL;
    tgt = 11'h123;
    #1 chk({10'h0, push}, 11'h001);
    chk(sdat, 11'h2f2);
    @(negedge core_clk) pc_op = CSRB_PC_HOLD;
    chk(pc, 11'h123);
    rd(7'h02, 8'h23);
    wr(7'h02, 8'h44);
    chk(pc, 11'h544);
    $display("program counter done");
    print_verdict;
  end
endmodule : test_core_special_register_bank
